// file: hw/cas_defs.vh
// Constants for the arithmetic/shift decode and execute core.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef CAS_DEFS_VH
`define CAS_DEFS_VH

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CAS_RESET_PC 16'h0100
`define CAS_RESET_ACC 8'h00
`define CAS_RESET_IDX 8'h00
`define CAS_RESET_MASK 1'b1

// ----------------------------------------
// Timing: oscillator clocks per CPU cycle
// ----------------------------------------
`define CAS_OSC_PER_CYC 2

// ----------------------------------------
// Flag positions in the flag_register port
// ----------------------------------------
`define CAS_FLAG_H 4
`define CAS_FLAG_I 3
`define CAS_FLAG_N 2
`define CAS_FLAG_Z 1
`define CAS_FLAG_C 0

// ----------------------------------------
// Addressing modes
// ----------------------------------------
`define CAS_MODE_LIT 4'h0
`define CAS_MODE_DIR 4'h1
`define CAS_MODE_FULL 4'h2
`define CAS_MODE_WOFS 4'h3
`define CAS_MODE_BOFS 4'h4
`define CAS_MODE_PLAIN 4'h5
`define CAS_MODE_IMPL 4'h6
`define CAS_MODE_REL 4'h7
`define CAS_MODE_BTB 4'h8

// ----------------------------------------
// Operations
// ----------------------------------------
`define CAS_OP_ADC 3'h0
`define CAS_OP_ADD 3'h1
`define CAS_OP_AND 3'h2
`define CAS_OP_SHL 3'h3
`define CAS_OP_BR 3'h4
`define CAS_OP_BTB 3'h5
`define CAS_OP_NONE 3'h7

// ----------------------------------------
// Opcode nibbles
// ----------------------------------------
`define CAS_LO_ADC 4'h9
`define CAS_LO_ADD 4'hB
`define CAS_LO_AND 4'h4
`define CAS_LO_SHL 4'h8
`define CAS_HI_LIT 4'hA
`define CAS_HI_DIR 4'hB
`define CAS_HI_FULL 4'hC
`define CAS_HI_WOFS 4'hD
`define CAS_HI_BOFS 4'hE
`define CAS_HI_PLAIN 4'hF
`define CAS_HI_SH_DIR 4'h3
`define CAS_HI_SH_A 4'h4
`define CAS_HI_SH_X 4'h5
`define CAS_HI_SH_BOFS 4'h6
`define CAS_HI_SH_PLAIN 4'h7
`define CAS_HI_REL 4'h2
`define CAS_HI_BTB 4'h0

// ----------------------------------------
// Cycle counts per instruction
// ----------------------------------------
`define CAS_CYC_LIT 3'd2
`define CAS_CYC_DIR 3'd3
`define CAS_CYC_FULL 3'd4
`define CAS_CYC_WOFS 3'd5
`define CAS_CYC_BOFS 3'd4
`define CAS_CYC_PLAIN 3'd3
`define CAS_CYC_SH_DIR 3'd5
`define CAS_CYC_SH_IMPL 3'd3
`define CAS_CYC_SH_BOFS 3'd6
`define CAS_CYC_SH_PLAIN 3'd5
`define CAS_CYC_REL 3'd3
`define CAS_CYC_BTB 3'd5
`define CAS_CYC_BAD 3'd1

`endif

// file: hw/cas_decode.v
// Opcode decoder: addressing mode, operation and cycle count.
// Assumes a plain combinational use; the caller muxes the opcode source.
`timescale 1ns/1ps
`include "cas_defs.vh"

module cas_decode (
	input wire [7:0] opc, // Opcode byte
	output reg [3:0] mode, // Addressing mode
	output reg [2:0] op, // Operation
	output reg [2:0] total, // CPU cycles incl. opcode fetch
	output reg legal // Opcode is handled here
);

wire [3:0] hi = opc[7:4];
wire [3:0] lo = opc[3:0];

always @* begin
	mode = `CAS_MODE_IMPL;
	op = `CAS_OP_NONE;
	total = `CAS_CYC_BAD;
	legal = 1'b0;
	if (hi >= `CAS_HI_LIT && (lo == `CAS_LO_ADC || lo == `CAS_LO_ADD || lo == `CAS_LO_AND)) begin
		legal = 1'b1;
		if (lo == `CAS_LO_ADC)
			op = `CAS_OP_ADC;
		else if (lo == `CAS_LO_ADD)
			op = `CAS_OP_ADD;
		else
			op = `CAS_OP_AND;
		case (hi)
			`CAS_HI_LIT: begin
				mode = `CAS_MODE_LIT;
				total = `CAS_CYC_LIT;
			end
			`CAS_HI_DIR: begin
				mode = `CAS_MODE_DIR;
				total = `CAS_CYC_DIR;
			end
			`CAS_HI_FULL: begin
				mode = `CAS_MODE_FULL;
				total = `CAS_CYC_FULL;
			end
			`CAS_HI_WOFS: begin
				mode = `CAS_MODE_WOFS;
				total = `CAS_CYC_WOFS;
			end
			`CAS_HI_BOFS: begin
				mode = `CAS_MODE_BOFS;
				total = `CAS_CYC_BOFS;
			end
			default: begin
				mode = `CAS_MODE_PLAIN;
				total = `CAS_CYC_PLAIN;
			end
		endcase
	end else if (lo == `CAS_LO_SHL && hi >= `CAS_HI_SH_DIR && hi <= `CAS_HI_SH_PLAIN) begin
		legal = 1'b1;
		op = `CAS_OP_SHL;
		case (hi)
			`CAS_HI_SH_DIR: begin
				mode = `CAS_MODE_DIR;
				total = `CAS_CYC_SH_DIR;
			end
			`CAS_HI_SH_A, `CAS_HI_SH_X: begin
				mode = `CAS_MODE_IMPL;
				total = `CAS_CYC_SH_IMPL;
			end
			`CAS_HI_SH_BOFS: begin
				mode = `CAS_MODE_BOFS;
				total = `CAS_CYC_SH_BOFS;
			end
			default: begin
				mode = `CAS_MODE_PLAIN;
				total = `CAS_CYC_SH_PLAIN;
			end
		endcase
	end else if (hi == `CAS_HI_REL) begin
		legal = 1'b1;
		mode = `CAS_MODE_REL;
		op = `CAS_OP_BR;
		total = `CAS_CYC_REL;
	end else if (hi == `CAS_HI_BTB) begin
		legal = 1'b1;
		mode = `CAS_MODE_BTB;
		op = `CAS_OP_BTB;
		total = `CAS_CYC_BTB;
	end
end

endmodule // cas_decode

// file: hw/cas_alu.v
// Arithmetic unit: add with and without carry, conjunction, shift left.
// Assumes the caller chooses which flags to keep for each operation.
`timescale 1ns/1ps
`include "cas_defs.vh"

module cas_alu (
	input wire [2:0] op, // Operation
	input wire [7:0] a, // Register operand
	input wire [7:0] m, // Memory operand
	input wire cin, // Carry in
	output reg [7:0] res, // Result
	output reg h, // Half carry
	output reg n, // Negative
	output reg z, // Zero
	output reg c // Carry out
);

reg [8:0] sum;
reg [4:0] low;
reg cadd;

always @* begin
	cadd = (op == `CAS_OP_ADC) ? cin : 1'b0;
	sum = {1'b0, a} + {1'b0, m} + {8'h00, cadd};
	low = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, cadd};
	res = sum[7:0];
	h = low[4];
	c = sum[8];
	if (op == `CAS_OP_AND) begin
		res = a & m;
		h = 1'b0;
		c = 1'b0;
	end else if (op == `CAS_OP_SHL) begin
		// Same datapath serves the logical shift left form
		res = {a[6:0], 1'b0};
		h = 1'b0;
		c = a[7];
	end
	n = res[7];
	z = (res == 8'h00);
end

endmodule // cas_alu

// file: hw/cas_core.v
// Execute core for add, add-with-carry, conjunction, shift left and branches.
// Assumes a same-clock memory whose MEM_RDATA follows MEM_ADDR within one CPU cycle (two CLKs).
`timescale 1ns/1ps
`include "cas_defs.vh"

// Function
// - CPU cycle lasts two oscillator clocks
// - Memory ops: 2,3,4,5,4,3 cycles by mode
// - High nibble mode, low nibble operation
// - Add and add-with-carry set H,N,Z,C
// - Conjunction updates only N and Z
// - Shift left opcodes, cycles, N Z C
// - Full address: high byte then low
// - Word offset high first, plus index
// - Byte offset added unsigned to index
// - Direct byte addresses first 256 locations
// - Bit branch: address byte then offset
// - Relative branch carries one offset byte
// - Target is next address plus offset
module cas_core (
	input wire CLK, // 25 MHz oscillator clock
	input wire RESETN, // Async reset, active low
	output reg [15:0] MEM_ADDR, // Memory address
	input wire [7:0] MEM_RDATA, // Memory read data
	output reg [7:0] MEM_WDATA, // Memory write data
	output reg MEM_WE, // Write enable, whole CPU cycle
	output reg MEM_RE, // Read request, whole CPU cycle
	output reg MEM_PHASE, // Second half of CPU cycle
	input wire IRQN_PIN, // Interrupt pin level, async
	input wire REG_LOAD, // Preload registers, restart fetch
	input wire [7:0] LOAD_ACC, // Accumulator preload
	input wire [7:0] LOAD_IDX, // Index preload
	input wire [15:0] LOAD_PC, // Program counter preload
	input wire [4:0] LOAD_FLAGS, // Flag preload
	output reg [7:0] ACC, // Accumulator
	output reg [7:0] IDX, // Index register
	output reg [15:0] PC, // Program counter
	output reg [4:0] FLAGS, // flag_register H I N Z C
	output reg INSTR_DONE, // Instruction retired pulse
	output reg BAD_OPCODE // Unhandled opcode pulse
);

// ----------------------------------------
// States
// ----------------------------------------
localparam S_OP = 3'd0;
localparam S_B1 = 3'd1;
localparam S_B2 = 3'd2;
localparam S_RD = 3'd3;
localparam S_WR = 3'd4;
localparam S_PAD = 3'd5;

reg [2:0] state_r, state_nxt;
reg phase_r;
reg [7:0] opcode_r, opcode_nxt;
reg [7:0] b1_r, b1_nxt;
reg [7:0] b2_r, b2_nxt;
reg [15:0] ea_r, ea_nxt;
reg [2:0] cyc_r, cyc_nxt;
reg [15:0] pc_nxt, addr_nxt;
reg [7:0] acc_nxt, idx_nxt, wdata_nxt;
reg [4:0] flags_nxt;
reg we_nxt, re_nxt, done_nxt, bad_nxt, fin;
reg irq_s1_r, irq_s2_r;

// ----------------------------------------
// Decode and arithmetic
// ----------------------------------------
wire [7:0] dec_in = (state_r == S_OP) ? MEM_RDATA : opcode_r;
wire [3:0] dmode;
wire [2:0] dop;
wire [2:0] dtotal;
wire dlegal;

cas_decode u_dec (
	.opc(dec_in),
	.mode(dmode),
	.op(dop),
	.total(dtotal),
	.legal(dlegal)
);

wire sh_idx = (dmode == `CAS_MODE_IMPL) && (dec_in[7:4] == `CAS_HI_SH_X);
wire [7:0] alu_a = (state_r == S_RD && dop == `CAS_OP_SHL) ? MEM_RDATA : (sh_idx ? IDX : ACC);
wire [7:0] alu_res;
wire alu_h, alu_n, alu_z, alu_c;

cas_alu u_alu (
	.op(dop),
	.a(alu_a),
	.m(MEM_RDATA),
	.cin(FLAGS[`CAS_FLAG_C]),
	.res(alu_res),
	.h(alu_h),
	.n(alu_n),
	.z(alu_z),
	.c(alu_c)
);

// ----------------------------------------
// Branch conditions
// ----------------------------------------
reg cond;
always @* begin
	case (opcode_r[3:1])
		3'd0: cond = 1'b0;
		3'd1: cond = FLAGS[`CAS_FLAG_C] | FLAGS[`CAS_FLAG_Z];
		3'd2: cond = FLAGS[`CAS_FLAG_C];
		3'd3: cond = FLAGS[`CAS_FLAG_Z];
		3'd4: cond = FLAGS[`CAS_FLAG_H];
		3'd5: cond = FLAGS[`CAS_FLAG_N];
		3'd6: cond = FLAGS[`CAS_FLAG_I];
		default: cond = irq_s2_r;
	endcase
end

// Even opcode tests the condition false, odd inverts
wire rel_taken = ~cond ^ opcode_r[0];
wire btb_bit = MEM_RDATA[opcode_r[3:1]];
wire btb_taken = btb_bit ^ opcode_r[0];
wire [15:0] pc_inc = PC + 16'h0001;
wire [15:0] rel_tgt = pc_inc + {{8{MEM_RDATA[7]}}, MEM_RDATA};
wire [15:0] btb_tgt = PC + {{8{b2_r[7]}}, b2_r};
wire [2:0] cyc_done = cyc_r + 3'd1;

// ----------------------------------------
// Per CPU cycle step
// ----------------------------------------
always @* begin
	state_nxt = state_r;
	opcode_nxt = opcode_r;
	b1_nxt = b1_r;
	b2_nxt = b2_r;
	ea_nxt = ea_r;
	pc_nxt = PC;
	acc_nxt = ACC;
	idx_nxt = IDX;
	flags_nxt = FLAGS;
	cyc_nxt = cyc_done;
	wdata_nxt = MEM_WDATA;
	we_nxt = 1'b0;
	done_nxt = 1'b0;
	bad_nxt = 1'b0;
	fin = 1'b0;
	case (state_r)
		S_OP: begin
			opcode_nxt = MEM_RDATA;
			pc_nxt = pc_inc;
			if (!dlegal) begin
				bad_nxt = 1'b1;
				fin = 1'b1;
			end else if (dmode == `CAS_MODE_PLAIN) begin
				ea_nxt = {8'h00, IDX};
				state_nxt = S_RD;
			end else if (dmode == `CAS_MODE_IMPL) begin
				if (sh_idx)
					idx_nxt = alu_res;
				else
					acc_nxt = alu_res;
				flags_nxt[`CAS_FLAG_N] = alu_n;
				flags_nxt[`CAS_FLAG_Z] = alu_z;
				flags_nxt[`CAS_FLAG_C] = alu_c;
				fin = 1'b1;
			end else begin
				state_nxt = S_B1;
			end
		end
		S_B1: begin
			b1_nxt = MEM_RDATA;
			pc_nxt = pc_inc;
			case (dmode)
				`CAS_MODE_LIT: begin
					acc_nxt = alu_res;
					flags_nxt[`CAS_FLAG_N] = alu_n;
					flags_nxt[`CAS_FLAG_Z] = alu_z;
					if (dop != `CAS_OP_AND) begin
						flags_nxt[`CAS_FLAG_H] = alu_h;
						flags_nxt[`CAS_FLAG_C] = alu_c;
					end
					fin = 1'b1;
				end
				`CAS_MODE_DIR: begin
					ea_nxt = {8'h00, MEM_RDATA};
					state_nxt = S_RD;
				end
				`CAS_MODE_BOFS: begin
					ea_nxt = {8'h00, IDX} + {8'h00, MEM_RDATA};
					state_nxt = S_RD;
				end
				`CAS_MODE_REL: begin
					if (rel_taken)
						pc_nxt = rel_tgt;
					fin = 1'b1;
				end
				default: state_nxt = S_B2;
			endcase
		end
		S_B2: begin
			pc_nxt = pc_inc;
			state_nxt = S_RD;
			if (dmode == `CAS_MODE_FULL)
				ea_nxt = {b1_r, MEM_RDATA};
			else if (dmode == `CAS_MODE_WOFS)
				ea_nxt = {b1_r, MEM_RDATA} + {8'h00, IDX};
			else begin
				b2_nxt = MEM_RDATA;
				ea_nxt = {8'h00, b1_r};
			end
		end
		S_RD: begin
			if (dop == `CAS_OP_SHL) begin
				wdata_nxt = alu_res;
				we_nxt = 1'b1;
				flags_nxt[`CAS_FLAG_N] = alu_n;
				flags_nxt[`CAS_FLAG_Z] = alu_z;
				flags_nxt[`CAS_FLAG_C] = alu_c;
				state_nxt = S_WR;
			end else if (dop == `CAS_OP_BTB) begin
				flags_nxt[`CAS_FLAG_C] = btb_bit;
				if (btb_taken)
					pc_nxt = btb_tgt;
				fin = 1'b1;
			end else begin
				acc_nxt = alu_res;
				flags_nxt[`CAS_FLAG_N] = alu_n;
				flags_nxt[`CAS_FLAG_Z] = alu_z;
				if (dop != `CAS_OP_AND) begin
					flags_nxt[`CAS_FLAG_H] = alu_h;
					flags_nxt[`CAS_FLAG_C] = alu_c;
				end
				fin = 1'b1;
			end
		end
		default: fin = 1'b1;
	endcase
	// Pad out to the documented count; work finishes early in most modes
	if (fin) begin
		if (cyc_done >= dtotal) begin
			state_nxt = S_OP;
			cyc_nxt = 3'd0;
			done_nxt = 1'b1;
		end else begin
			state_nxt = S_PAD;
		end
	end
	addr_nxt = MEM_ADDR;
	re_nxt = 1'b0;
	if (state_nxt == S_OP || state_nxt == S_B1 || state_nxt == S_B2) begin
		addr_nxt = pc_nxt;
		re_nxt = 1'b1;
	end else if (state_nxt == S_RD) begin
		addr_nxt = ea_nxt;
		re_nxt = 1'b1;
	end else if (state_nxt == S_WR) begin
		addr_nxt = ea_nxt;
	end
end

// ----------------------------------------
// Registers
// ----------------------------------------
always @(posedge CLK or negedge RESETN) begin
	if (!RESETN) begin
		irq_s1_r <= 1'b1;
		irq_s2_r <= 1'b1;
	end else begin
		irq_s1_r <= IRQN_PIN;
		irq_s2_r <= irq_s1_r;
	end
end

always @(posedge CLK or negedge RESETN) begin
	if (!RESETN) begin
		phase_r <= 1'b0;
		state_r <= S_OP;
		opcode_r <= 8'h00;
		b1_r <= 8'h00;
		b2_r <= 8'h00;
		ea_r <= 16'h0000;
		cyc_r <= 3'd0;
		PC <= `CAS_RESET_PC;
		ACC <= `CAS_RESET_ACC;
		IDX <= `CAS_RESET_IDX;
		FLAGS <= {1'b0, `CAS_RESET_MASK, 3'b000};
		MEM_ADDR <= `CAS_RESET_PC;
		MEM_WDATA <= 8'h00;
		MEM_WE <= 1'b0;
		MEM_RE <= 1'b1;
		MEM_PHASE <= 1'b0;
		INSTR_DONE <= 1'b0;
		BAD_OPCODE <= 1'b0;
	end else if (REG_LOAD) begin
		phase_r <= 1'b0;
		state_r <= S_OP;
		cyc_r <= 3'd0;
		PC <= LOAD_PC;
		ACC <= LOAD_ACC;
		IDX <= LOAD_IDX;
		FLAGS <= LOAD_FLAGS;
		MEM_ADDR <= LOAD_PC;
		MEM_WE <= 1'b0;
		MEM_RE <= 1'b1;
		MEM_PHASE <= 1'b0;
		INSTR_DONE <= 1'b0;
		BAD_OPCODE <= 1'b0;
	end else begin
		phase_r <= ~phase_r;
		MEM_PHASE <= ~phase_r;
		INSTR_DONE <= 1'b0;
		BAD_OPCODE <= 1'b0;
		// One step per two oscillator clocks
		if (phase_r) begin
			state_r <= state_nxt;
			opcode_r <= opcode_nxt;
			b1_r <= b1_nxt;
			b2_r <= b2_nxt;
			ea_r <= ea_nxt;
			cyc_r <= cyc_nxt;
			PC <= pc_nxt;
			ACC <= acc_nxt;
			IDX <= idx_nxt;
			FLAGS <= flags_nxt;
			MEM_ADDR <= addr_nxt;
			MEM_WDATA <= wdata_nxt;
			MEM_WE <= we_nxt;
			MEM_RE <= re_nxt;
			INSTR_DONE <= done_nxt;
			BAD_OPCODE <= bad_nxt;
		end
	end
end

endmodule // cas_core

// file: tb/cas_mem_model.sv
// Memory seen by the execute core: opcode, operand and data bytes.
// Assumes the core holds address and strobes for a whole CPU cycle.
`timescale 1ns/1ps

module cas_mem_model (
	input wire clk, // 25 MHz clock
	input wire slow, // Data only in second half
	input wire phase, // Second half of CPU cycle
	input wire [15:0] addr, // Address
	input wire re, // Read cycle
	input wire we, // Write cycle
	input wire [7:0] wdata, // Write data
	output wire [7:0] rdata // Read data
);
	reg [7:0] mem [0:65535];
	reg [7:0] last_r = 8'h00;
	integer i;

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	// Unhandled opcode everywhere, so runaway fetches stay harmless
	initial begin
		for (i = 0; i < 65536; i = i + 1)
			mem[i] = 8'h9D;
	end

	// Released bus shows the inverse of the last byte, never a stale match
	assign rdata = (re && (phase || !slow)) ? mem[addr] : ~last_r;

	always @(posedge clk) begin
		if (re)
			last_r <= mem[addr];
		if (we)
			mem[addr] <= wdata;
	end
endmodule // cas_mem_model

// file: tb/cas_core_checker.sv
// Timing checks on the execute core's memory cycles and flags.
// Assumes binding to cas_core; sees its ports only.
`timescale 1ns/1ps

module cas_core_checker (
	input wire CLK, // Clock
	input wire RESETN, // Async reset, active low
	input wire [15:0] MEM_ADDR, // Memory address
	input wire MEM_RE, // Read cycle
	input wire MEM_WE, // Write cycle
	input wire MEM_PHASE, // Second half of CPU cycle
	input wire REG_LOAD, // Preload strobe
	input wire [15:0] LOAD_PC, // Preload address
	input wire [4:0] FLAGS, // Flags H I N Z C
	input wire INSTR_DONE, // Retire pulse
	input wire BAD_OPCODE // Unhandled opcode pulse
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);

	// ----------------------------------------
	// Sequences
	// ----------------------------------------
	sequence s_fetch_start;
		!MEM_PHASE && MEM_RE && !MEM_WE;
	endsequence
	sequence s_write_then_free;
		MEM_WE ##1 !MEM_WE;
	endsequence

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_PHASE_TOGGLE: assert property (!REG_LOAD |=> MEM_PHASE != $past(MEM_PHASE))
		else $error("phase did not alternate");
	AST_CYCLE_STANDS: assert property (!MEM_PHASE && !REG_LOAD |=>
		$stable(MEM_ADDR) && $stable(MEM_RE) && $stable(MEM_WE)) else $error("bus changed mid cycle");
	AST_LOAD_FETCH: assert property (REG_LOAD |=> s_fetch_start and MEM_ADDR == $past(LOAD_PC))
		else $error("no fetch at preload address");
	AST_DONE_FETCH: assert property (INSTR_DONE |-> s_fetch_start ##1 !INSTR_DONE)
		else $error("retire not aligned to next fetch");
	AST_PAD_HOLDS: assert property (!$past(REG_LOAD) && !MEM_RE && !MEM_WE |-> $stable(MEM_ADDR))
		else $error("pad cycle moved address");
	AST_MASK_KEPT: assert property (!$past(REG_LOAD) |-> $stable(FLAGS[3]))
		else $error("interrupt mask changed");
	AST_BAD_RETIRES: assert property (BAD_OPCODE |-> INSTR_DONE)
		else $error("bad opcode without retire");
	AST_WRITE_NO_READ: assert property (MEM_WE |-> !MEM_RE)
		else $error("read and write together");
	AST_WRITE_HOLD: assert property ($rose(MEM_WE) |=> s_write_then_free)
		else $error("write not one CPU cycle");
endmodule // cas_core_checker

// file: tb/tb_cas_core.sv
// Self-checking bench for the execute core, one task per scenario.
// Assumes the memory model and checker files compile before this one.
`timescale 1ns/1ps

module tb_cas_core;
	reg CLK = 1'b0;
	reg RESETN = 1'b0;
	reg REG_LOAD = 1'b0;
	reg IRQN_PIN = 1'b1;
	reg slow = 1'b0;
	reg [7:0] LOAD_ACC = 8'h00;
	reg [7:0] LOAD_IDX = 8'h00;
	reg [15:0] LOAD_PC = 16'h0000;
	reg [4:0] LOAD_FLAGS = 5'h00;
	wire [15:0] MEM_ADDR, PC;
	wire [7:0] MEM_RDATA, MEM_WDATA, ACC, IDX;
	wire [4:0] FLAGS;
	wire MEM_WE, MEM_RE, MEM_PHASE, INSTR_DONE, BAD_OPCODE;
	integer fail_count = 0;
	integer checks = 0;
	integer cyc = 0;

`define CHK(nm, e, v) begin checks = checks + 1; if ((v) !== (e)) begin fail_count = fail_count + 1; \
	$display("ERROR %s expected %h seen %h", nm, e, v); end end

	cas_core u_dut (.CLK(CLK), .RESETN(RESETN), .MEM_ADDR(MEM_ADDR), .MEM_RDATA(MEM_RDATA),
		.MEM_WDATA(MEM_WDATA), .MEM_WE(MEM_WE), .MEM_RE(MEM_RE), .MEM_PHASE(MEM_PHASE), .IRQN_PIN(IRQN_PIN),
		.REG_LOAD(REG_LOAD), .LOAD_ACC(LOAD_ACC), .LOAD_IDX(LOAD_IDX), .LOAD_PC(LOAD_PC), .LOAD_FLAGS(LOAD_FLAGS),
		.ACC(ACC), .IDX(IDX), .PC(PC), .FLAGS(FLAGS), .INSTR_DONE(INSTR_DONE), .BAD_OPCODE(BAD_OPCODE));
	cas_mem_model u_mem (.clk(CLK), .slow(slow), .phase(MEM_PHASE), .addr(MEM_ADDR), .re(MEM_RE),
		.we(MEM_WE), .wdata(MEM_WDATA), .rdata(MEM_RDATA));

	always #20 CLK = ~CLK;

	// Whole run is a few hundred clocks; far beyond that means a hang
	always @(posedge CLK) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			fail_count = fail_count + 1;
			summarize;
		end
	end

	task summarize;
		begin
			if (fail_count == 0 && checks > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask

	// ----------------------------------------
	// Preload, run one instruction, judge
	// ----------------------------------------
	task run(input [23:0] code, input [7:0] a, input [7:0] x, input [4:0] f, input integer c, input [7:0] ea,
		input [4:0] ef, input [15:0] ep);
		integer n;
		begin
			u_mem.mem[16'h0200] = code[23:16];
			u_mem.mem[16'h0201] = code[15:8];
			u_mem.mem[16'h0202] = code[7:0];
			@(negedge CLK);
			LOAD_ACC = a;
			LOAD_IDX = x;
			LOAD_FLAGS = f;
			LOAD_PC = 16'h0200;
			REG_LOAD = 1'b1;
			@(negedge CLK);
			REG_LOAD = 1'b0;
			n = 0;
			do begin
				@(negedge CLK);
				n = n + 1;
			end while (INSTR_DONE !== 1'b1 && n < 40);
			`CHK("clocks", 2 * c, n)
			`CHK("acc", ea, ACC)
			`CHK("flags", ef, FLAGS)
			`CHK("pc", ep, PC)
		end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_arith;
		begin
			run(24'hA9_019D, 8'h0F, 8'h00, 5'h09, 2, 8'h11, 5'h18, 16'h0202);
			run(24'hAB_809D, 8'h80, 8'h00, 5'h08, 2, 8'h00, 5'h0B, 16'h0202);
			run(24'hA4_0F9D, 8'hF0, 8'h00, 5'h19, 2, 8'h00, 5'h1B, 16'h0202);
		end
	endtask

	// Operand only valid late in the cycle here
	task t_modes;
		begin
			slow = 1'b1;
			u_mem.mem[16'h0040] = 8'h05;
			u_mem.mem[16'h1234] = 8'h05;
			u_mem.mem[16'h1110] = 8'h05;
			u_mem.mem[16'h01FE] = 8'h05;
			u_mem.mem[16'h0080] = 8'h05;
			run(24'hBB_409D, 8'h10, 8'h00, 5'h08, 3, 8'h15, 5'h08, 16'h0202);
			run(24'hCB_1234, 8'h10, 8'h00, 5'h08, 4, 8'h15, 5'h08, 16'h0203);
			run(24'hDB_1020, 8'h10, 8'hF0, 5'h08, 5, 8'h15, 5'h08, 16'h0203);
			run(24'hEB_FF9D, 8'h10, 8'hFF, 5'h08, 4, 8'h15, 5'h08, 16'h0202);
			run(24'hFB_9D9D, 8'h10, 8'h80, 5'h08, 3, 8'h15, 5'h08, 16'h0201);
			slow = 1'b0;
		end
	endtask

	task t_shift;
		begin
			run(24'h48_9D9D, 8'h81, 8'h00, 5'h08, 3, 8'h02, 5'h09, 16'h0201);
			run(24'h58_9D9D, 8'h33, 8'hC0, 5'h08, 3, 8'h33, 5'h0D, 16'h0201);
			`CHK("idx", 8'h80, IDX)
			u_mem.mem[16'h0040] = 8'h80;
			run(24'h38_409D, 8'h33, 8'h00, 5'h08, 5, 8'h33, 5'h0B, 16'h0202);
			`CHK("mem dir", 8'h00, u_mem.mem[16'h0040])
			u_mem.mem[16'h0030] = 8'h40;
			run(24'h68_109D, 8'h33, 8'h20, 5'h08, 6, 8'h33, 5'h0C, 16'h0202);
			`CHK("mem byte ofs", 8'h80, u_mem.mem[16'h0030])
			u_mem.mem[16'h0050] = 8'h01;
			run(24'h78_9D9D, 8'h33, 8'h50, 5'h08, 5, 8'h33, 5'h08, 16'h0201);
			`CHK("mem plain", 8'h02, u_mem.mem[16'h0050])
		end
	endtask

	task t_branch;
		begin
			run(24'h20_7F9D, 8'h00, 8'h00, 5'h08, 3, 8'h00, 5'h08, 16'h0281);
			run(24'h20_809D, 8'h00, 8'h00, 5'h08, 3, 8'h00, 5'h08, 16'h0182);
			run(24'h2F_049D, 8'h00, 8'h00, 5'h08, 3, 8'h00, 5'h08, 16'h0206);
			run(24'h27_409D, 8'h00, 8'h00, 5'h08, 3, 8'h00, 5'h08, 16'h0202);
			run(24'h27_F09D, 8'h00, 8'h00, 5'h0A, 3, 8'h00, 5'h0A, 16'h01F2);
			// Pin low long before the offset cycle; synchroniser needs two clocks
			IRQN_PIN = 1'b0;
			run(24'h2E_049D, 8'h00, 8'h00, 5'h08, 3, 8'h00, 5'h08, 16'h0206);
			run(24'h2F_049D, 8'h00, 8'h00, 5'h08, 3, 8'h00, 5'h08, 16'h0202);
			IRQN_PIN = 1'b1;
			u_mem.mem[16'h0060] = 8'h01;
			run(24'h00_6010, 8'h00, 8'h00, 5'h08, 5, 8'h00, 5'h09, 16'h0213);
			run(24'h01_60F0, 8'h00, 8'h00, 5'h08, 5, 8'h00, 5'h09, 16'h0203);
			run(24'h9D_9D9D, 8'h00, 8'h00, 5'h08, 1, 8'h00, 5'h08, 16'h0201);
			`CHK("bad", 1'b1, BAD_OPCODE)
		end
	endtask

	initial begin
		repeat (2) @(negedge CLK);
		RESETN = 1'b1;
		t_arith;
		t_modes;
		t_shift;
		t_branch;
		summarize;
	end
endmodule // tb_cas_core

bind cas_core cas_core_checker u_chk (.CLK(CLK), .RESETN(RESETN), .MEM_ADDR(MEM_ADDR), .MEM_RE(MEM_RE),
	.MEM_WE(MEM_WE), .MEM_PHASE(MEM_PHASE), .REG_LOAD(REG_LOAD), .LOAD_PC(LOAD_PC), .FLAGS(FLAGS),
	.INSTR_DONE(INSTR_DONE), .BAD_OPCODE(BAD_OPCODE));
